// ### core/rs_pkg.sv
// How it works
// [R1] Four fast inputs, each plain, latched or event by its function field; the rest are plain.
// [R2] Each input has a debounce filter whose length is chosen by the input's function.
// [R3] A latched input catches a pulse shorter than a scan and shows it in the next scan image.
// [R4] Only rising edges set the latch; falling edges never do.
// [R5] An event input fires a task trigger on its selected edge: rising, falling or both.
// [R6] Only one input can serve as extra run/stop; a second assignment is refused.
// [R7] Run/stop comes from the switch, from software commands and from the assigned input.
// [R8] With the switch at stop the unit stays stopped and ignores every other command.
// [R9] Switch stop-to-run starts; at run, software commands apply if the input is absent or high.
// [R10] An assigned input at 0 forces stop; its rising edge or a switch move while high starts.
// [R11] Stopped or in exception, all outputs take the application default values.
// [R12] A short or overcurrent drives all outputs to 0, then retries every 10 seconds.
// [R13] An option inhibits the automatic retry so outputs stay off after a trip.
// [R14] System date and time are handed to the left-side expansion modules.
// [R15] A latch indication clears after one presented scan unless a new rising edge came.
package rs_pkg;
    localparam int NUM_IN = 4;
    localparam int NUM_OUT = 8;
    localparam int IRQ_W = 6;
    // Register offsets
    localparam logic [5:0] REG_CMD = 6'h00;
    localparam logic [5:0] REG_IN_CFG = 6'h04;
    localparam logic [5:0] REG_RS_CFG = 6'h08;
    localparam logic [5:0] REG_FILT = 6'h0C;
    localparam logic [5:0] REG_OUT_CFG = 6'h10;
    localparam logic [5:0] REG_OUT_VAL = 6'h14;
    localparam logic [5:0] REG_OUT_DEF = 6'h18;
    localparam logic [5:0] REG_SCAN = 6'h1C;
    localparam logic [5:0] REG_STATUS = 6'h20;
    localparam logic [5:0] REG_IRQ_STAT = 6'h24;
    localparam logic [5:0] REG_IRQ_MASK = 6'h28;
    localparam logic [5:0] REG_TIME = 6'h2C;
    // Field positions
    localparam int CMD_RUN = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_REARM = 2;
    localparam int RS_EN = 0;
    localparam int RS_SEL_LSB = 1;
    localparam int EDGE_LSB = 8;
    localparam int FILT_EVT_LSB = 8;
    localparam int OUT_INHIBIT = 0;
    localparam int STAT_RUN = 0;
    localparam int STAT_PROT = 1;
    localparam int STAT_EXC = 2;
    localparam int STAT_IN_LSB = 4;
    localparam int IRQ_FAULT = 4;
    localparam int IRQ_RUN = 5;
    // Reset values
    localparam logic [15:0] IN_CFG_RST = 16'h0000;
    localparam logic [2:0] RS_CFG_RST = 3'h0;
    localparam logic [15:0] FILT_RST = 16'h0404;
    localparam logic [7:0] OUT_RST = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST = 6'h00;
    // Input functions and edge selects
    localparam logic [1:0] FN_LATCH = 2'h1;
    localparam logic [1:0] FN_EVENT = 2'h2;
    localparam int EDGE_RISE = 0;
    localparam int EDGE_FALL = 1;
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int FILT_TICK_NS = 1000;
    localparam logic [7:0] FILT_TICK_CYC = 8'((FILT_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [63:0] REARM_S = 64'd10;
    localparam logic [63:0] NS_PER_S = 64'd1000000000;
    localparam logic [31:0] REARM_CYC = 32'(REARM_S * NS_PER_S / 64'(CLK_PERIOD_NS));
    typedef enum logic [1:0] {ST_STOP = 2'b01, ST_RUN = 2'b10} run_state_e;
    typedef enum logic [1:0] {PR_ARMED = 2'b01, PR_OFF = 2'b10} prot_state_e;
endpackage

// ### core/in_filter.sv
`timescale 1ns/1ps
`default_nettype none
module in_filter (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic raw,
    input wire logic tick,
    input wire logic [7:0] limit,
    output logic level
);
    logic [7:0] cnt;

    // Level follows only after raw held for limit ticks
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 8'h00;
            level <= 1'b0;
        end else if (raw == level) begin
            cnt <= 8'h00;
        end else if (cnt >= limit) begin // R2
            level <= raw;
            cnt <= 8'h00;
        end else if (tick) begin
            cnt <= cnt + 8'h01;
        end
    end

    a_filter_hold: assert property (@(posedge clock) disable iff (!rst_n)
        $changed(level) |-> $past(raw) == level && $past(cnt) >= $past(limit)) // R2
        else $error("filtered level changed without a held raw level");
endmodule
`default_nettype wire

// ### core/out_protect.sv
`timescale 1ns/1ps
`default_nettype none
module out_protect #(
    parameter logic [31:0] REARM_CYCLES = rs_pkg::REARM_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic fault,
    input wire logic inhibit,
    input wire logic rearm_req,
    output logic outputs_off,
    output logic trip
);
    import rs_pkg::*;
    prot_state_e state;
    logic [31:0] cnt;

    assign trip = (state == PR_ARMED) && fault;
    assign outputs_off = (state != PR_ARMED);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state <= PR_ARMED;
        end else begin
            case (state)
                PR_ARMED: begin
                    if (fault) begin
                        state <= PR_OFF; // R12
                    end
                end
                PR_OFF: begin
                    if (rearm_req || (!inhibit && cnt >= REARM_CYCLES - 32'd1)) begin // R12 R13
                        state <= PR_ARMED;
                    end
                end
                default: begin
                    state <= PR_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 32'h00000000;
        end else if (state != PR_OFF) begin
            cnt <= 32'h00000000;
        end else if (cnt < REARM_CYCLES - 32'd1) begin
            cnt <= cnt + 32'd1;
        end
    end

    a_rearm_inhibit: assert property (@(posedge clock) disable iff (!rst_n)
        state == PR_OFF && inhibit && !rearm_req |=> state == PR_OFF) // R13
        else $error("outputs rearmed while rearm inhibited");
    a_rearm_period: assert property (@(posedge clock) disable iff (!rst_n)
        state == PR_OFF && !rearm_req && cnt < REARM_CYCLES - 32'd1 |=> state == PR_OFF) // R12
        else $error("outputs rearmed before the retry period");
endmodule
`default_nettype wire

// ### core/run_stop_io_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module run_stop_io_supervisor #(
    parameter logic [31:0] REARM_CYCLES = rs_pkg::REARM_CYC
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [5:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [rs_pkg::NUM_IN-1:0] fast_in,
    input wire logic run_switch,
    input wire logic short_fault,
    input wire logic exc_state,
    output logic [rs_pkg::NUM_IN-1:0] task_trigger,
    output logic [rs_pkg::NUM_OUT-1:0] out_drive,
    output logic run_active,
    output logic irq,
    output logic [31:0] ext_time,
    output logic ext_time_valid
);
    import rs_pkg::*;

    function automatic logic [1:0] pick2(input logic [15:0] v, input int i);
        pick2 = v[2*i +: 2];
    endfunction

    // ==========================================================
    // Pin synchronisers
    logic [NUM_IN+1:0] sync1;
    logic [NUM_IN+1:0] sync2;
    logic sw_s;
    logic fault_s;
    logic [NUM_IN-1:0] in_s;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= {short_fault, run_switch, fast_in};
            sync2 <= sync1;
        end
    end

    assign in_s = sync2[NUM_IN-1:0];
    assign sw_s = sync2[NUM_IN];
    assign fault_s = sync2[NUM_IN+1];

    // ==========================================================
    // Register file
    logic [15:0] in_cfg;
    logic [2:0] rs_cfg;
    logic [15:0] filt;
    logic inhibit;
    logic [NUM_OUT-1:0] out_val;
    logic [NUM_OUT-1:0] out_def;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_set;
    logic sw_run_req;
    logic sw_stop_req;
    logic rearm_req;
    logic scan_strobe;
    logic rs_en;
    logic [1:0] rs_sel;
    logic rs_write_ok;

    assign sw_run_req = wr && addr == REG_CMD && wdata[CMD_RUN]; // R7
    assign sw_stop_req = wr && addr == REG_CMD && wdata[CMD_STOP]; // R7
    assign rearm_req = wr && addr == REG_CMD && wdata[CMD_REARM];
    assign scan_strobe = wr && addr == REG_SCAN;
    assign rs_en = rs_cfg[RS_EN];
    assign rs_sel = rs_cfg[RS_SEL_LSB +: 2];
    // Moving the run/stop role needs a disable first
    assign rs_write_ok = !rs_en || !wdata[RS_EN] || wdata[RS_SEL_LSB +: 2] == rs_sel; // R6

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            in_cfg <= IN_CFG_RST;
            filt <= FILT_RST;
            inhibit <= 1'b0;
            out_val <= OUT_RST;
            out_def <= OUT_RST;
            irq_mask <= IRQ_RST;
        end else if (wr) begin
            case (addr)
                REG_IN_CFG: in_cfg <= wdata[15:0]; // R1
                REG_FILT: filt <= wdata[15:0];
                REG_OUT_CFG: inhibit <= wdata[OUT_INHIBIT]; // R13
                REG_OUT_VAL: out_val <= wdata[NUM_OUT-1:0];
                REG_OUT_DEF: out_def <= wdata[NUM_OUT-1:0];
                REG_IRQ_MASK: irq_mask <= wdata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rs_cfg <= RS_CFG_RST;
        end else if (wr && addr == REG_RS_CFG && rs_write_ok) begin // R6
            rs_cfg <= wdata[2:0];
        end
    end

    // Time handed to left-side expansion with a one-cycle strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ext_time <= 32'h00000000;
            ext_time_valid <= 1'b0;
        end else begin
            ext_time_valid <= wr && addr == REG_TIME; // R14
            if (wr && addr == REG_TIME) begin
                ext_time <= wdata;
            end
        end
    end

    // ==========================================================
    // Filters and edges
    logic [7:0] tick_cnt;
    logic tick;
    logic [NUM_IN-1:0] lvl;
    logic [NUM_IN-1:0] lvl_q;
    logic [NUM_IN-1:0] rise;
    logic [NUM_IN-1:0] fall;
    logic [NUM_IN-1:0] is_latch;
    logic [NUM_IN-1:0] is_event;
    logic [NUM_IN-1:0] evt;

    assign tick = tick_cnt == FILT_TICK_CYC - 8'h01;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 8'h00;
        end else if (tick) begin
            tick_cnt <= 8'h00;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            logic [1:0] edge_sel;
            assign edge_sel = pick2(in_cfg >> EDGE_LSB, gi);
            assign is_latch[gi] = pick2(in_cfg, gi) == FN_LATCH; // R1
            assign is_event[gi] = pick2(in_cfg, gi) == FN_EVENT; // R1
            assign evt[gi] = is_event[gi] && // R5
                ((edge_sel[EDGE_RISE] && rise[gi]) || (edge_sel[EDGE_FALL] && fall[gi]));
            in_filter u_filter (
                .clock(clock),
                .rst_n(rst_n),
                .raw(in_s[gi]),
                .tick(tick),
                .limit(is_event[gi] ? filt[FILT_EVT_LSB +: 8] : filt[7:0]), // R2
                .level(lvl[gi])
            );
        end
    endgenerate

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lvl_q <= '0;
        end else begin
            lvl_q <= lvl;
        end
    end

    assign rise = lvl & ~lvl_q;
    assign fall = ~lvl & lvl_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            task_trigger <= '0;
        end else begin
            task_trigger <= evt; // R5
        end
    end

    // ==========================================================
    // Latch capture and scan image
    logic [NUM_IN-1:0] pend;
    logic [NUM_IN-1:0] image;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pend <= '0;
        end else if (scan_strobe) begin
            pend <= rise & is_latch; // R15
        end else begin
            pend <= pend | (rise & is_latch); // R3 R4
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            image <= '0;
        end else if (scan_strobe) begin
            image <= (is_latch & (pend | rise)) | (~is_latch & lvl); // R3 R1
        end
    end

    // ==========================================================
    // Run/stop state
    run_state_e run_state;
    run_state_e next_run;
    logic sw_q;
    logic sw_rise;
    logic rs_level;
    logic rs_rise;
    logic run_allowed;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sw_q <= 1'b0;
        end else begin
            sw_q <= sw_s;
        end
    end

    assign sw_rise = sw_s && !sw_q;
    assign rs_level = lvl[rs_sel];
    assign rs_rise = rise[rs_sel];
    assign run_allowed = sw_s && (!rs_en || rs_level); // R8 R10

    always_comb begin
        next_run = run_state;
        case (run_state)
            ST_STOP: begin
                if (run_allowed && (sw_rise || sw_run_req || (rs_en && rs_rise))) begin // R9 R10
                    next_run = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!run_allowed || sw_stop_req) begin // R8 R9 R10
                    next_run = ST_STOP;
                end
            end
            default: begin
                next_run = ST_STOP;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            run_state <= ST_STOP;
        end else begin
            run_state <= next_run; // R7
        end
    end

    assign run_active = run_state == ST_RUN;

    // ==========================================================
    // Output management
    logic prot_off;
    logic trip;

    out_protect #(.REARM_CYCLES(REARM_CYCLES)) u_protect (
        .clock(clock),
        .rst_n(rst_n),
        .fault(fault_s),
        .inhibit(inhibit),
        .rearm_req(rearm_req),
        .outputs_off(prot_off),
        .trip(trip)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            out_drive <= OUT_RST;
        end else if (prot_off) begin
            out_drive <= '0; // R12
        end else if (run_active && !exc_state) begin
            out_drive <= out_val;
        end else begin
            out_drive <= out_def; // R11
        end
    end

    // ==========================================================
    // Interrupts
    assign irq_set = {next_run != run_state, trip, evt};

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= IRQ_RST;
        end else if (wr && addr == REG_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~wdata[IRQ_W-1:0]) | irq_set;
        end else begin
            irq_stat <= irq_stat | irq_set;
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ==========================================================
    // Read port
    logic [31:0] rd_val;
    logic [31:0] status;

    always_comb begin
        status = 32'h00000000;
        status[STAT_RUN] = run_active;
        status[STAT_PROT] = prot_off;
        status[STAT_EXC] = exc_state;
        status[STAT_IN_LSB +: NUM_IN] = lvl;
    end

    always_comb begin
        rd_val = 32'h00000000;
        case (addr)
            REG_IN_CFG: rd_val[15:0] = in_cfg;
            REG_RS_CFG: rd_val[2:0] = rs_cfg;
            REG_FILT: rd_val[15:0] = filt;
            REG_OUT_CFG: rd_val[OUT_INHIBIT] = inhibit;
            REG_OUT_VAL: rd_val[NUM_OUT-1:0] = out_val;
            REG_OUT_DEF: rd_val[NUM_OUT-1:0] = out_def;
            REG_SCAN: rd_val[NUM_IN-1:0] = image;
            REG_STATUS: rd_val = status;
            REG_IRQ_STAT: rd_val[IRQ_W-1:0] = irq_stat;
            REG_IRQ_MASK: rd_val[IRQ_W-1:0] = irq_mask;
            REG_TIME: rd_val = ext_time;
            default: rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h00000000;
        end else begin
            rdata <= rd ? rd_val : 32'h00000000;
        end
    end

    // ==========================================================
    // Checks
    a_switch_stop_holds: assert property (@(posedge clock) disable iff (!rst_n) // R8
        !sw_s |=> run_state == ST_STOP)
        else $error("left stop while switch at stop");
    a_input_low_stops: assert property (@(posedge clock) disable iff (!rst_n) // R10
        rs_en && !rs_level |=> run_state == ST_STOP)
        else $error("run/stop input low did not force stop");
    a_switch_rise_runs: assert property (@(posedge clock) disable iff (!rst_n) // R9
        sw_rise && !sw_stop_req && (!rs_en || rs_level) |=> run_state == ST_RUN)
        else $error("switch stop-to-run did not start");
    a_input_rise_runs: assert property (@(posedge clock) disable iff (!rst_n) // R10
        sw_s && rs_en && rs_rise && !sw_stop_req |=> run_state == ST_RUN)
        else $error("run/stop input edge did not start");
    a_soft_stop: assert property (@(posedge clock) disable iff (!rst_n) // R9
        run_active && sw_stop_req |=> !run_active)
        else $error("software stop ignored");
    a_rs_reassign: assert property (@(posedge clock) disable iff (!rst_n) // R6
        rs_en && $stable(rs_en) |=> rs_sel == $past(rs_sel) || !rs_en)
        else $error("second run/stop input accepted");
    a_event_edge: assert property (@(posedge clock) disable iff (!rst_n) // R5
        is_event[NUM_IN-1] && in_cfg[EDGE_LSB + 2 * (NUM_IN - 1) + EDGE_FALL] &&
        fall[NUM_IN-1] |=> task_trigger[NUM_IN-1])
        else $error("falling edge event missed");
    a_latch_capture: assert property (@(posedge clock) disable iff (!rst_n) // R3
        is_latch[0] && pend[0] && scan_strobe |=> image[0])
        else $error("latched pulse not shown in next scan");
    a_latch_set: assert property (@(posedge clock) disable iff (!rst_n) // R3
        is_latch[0] && rise[0] |=> pend[0])
        else $error("rising edge not captured by the latch");
    a_latch_no_fall: assert property (@(posedge clock) disable iff (!rst_n) // R4
        fall[0] && !pend[0] |=> !pend[0])
        else $error("falling edge set the latch");
    a_latch_clears: assert property (@(posedge clock) disable iff (!rst_n) // R15
        scan_strobe && !rise[0] |=> !pend[0])
        else $error("latch not cleared after presentation");
    a_fallback_default: assert property (@(posedge clock) disable iff (!rst_n) // R11
        !prot_off && (!run_active || exc_state) |=> out_drive == $past(out_def))
        else $error("outputs not at default in stop or exception");
    a_fault_zero: assert property (@(posedge clock) disable iff (!rst_n) // R12
        trip |=> prot_off ##1 out_drive == '0)
        else $error("outputs not zeroed on fault");

    c_run_entered: cover property (@(posedge clock) disable iff (!rst_n)
        !run_active ##1 run_active);
    c_event_fired: cover property (@(posedge clock) disable iff (!rst_n) |task_trigger);
    c_fault_trip: cover property (@(posedge clock) disable iff (!rst_n) trip);
    c_latch_shown: cover property (@(posedge clock) disable iff (!rst_n)
        scan_strobe && pend[0] && is_latch[0]);
endmodule
`default_nettype wire

// ### tb/field_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Field side: sensors, operator switch, load short detect
module field_model (
    input wire logic clock,
    output logic [rs_pkg::NUM_IN-1:0] fast_in,
    output logic run_switch,
    output logic short_fault
);
    import rs_pkg::*;
    initial begin
        fast_in = '0;
        run_switch = 1'b0;
        short_fault = 1'b0;
    end
    // Contact bounce of b short toggles before settling
    task automatic set_in(input int i, input logic v, input int b);
        repeat (b) begin
            @(posedge clock);
            fast_in[i] <= ~fast_in[i];
        end
        @(posedge clock);
        fast_in[i] <= v;
    endtask
    task automatic pulse(input int i, input int n);
        set_in(i, 1'b1, 0);
        repeat (n) @(posedge clock);
        fast_in[i] <= 1'b0;
    endtask
    task automatic set_ctl(input logic sw, input logic flt);
        @(posedge clock);
        run_switch <= sw;
        short_fault <= flt;
    endtask
endmodule
`default_nettype wire

// ### tb/test_run_stop_io_supervisor.sv
`timescale 1ns/1ps
`default_nettype none
module test_run_stop_io_supervisor;
    import rs_pkg::*;
    localparam int LIMIT = 20000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic exc_state = 1'b0;
    logic [31:0] rdata;
    logic [3:0] fast_in;
    logic run_switch;
    logic short_fault;
    logic [3:0] task_trigger;
    logic [7:0] out_drive;
    logic run_active;
    logic irq;
    logic [31:0] ext_time;
    logic ext_time_valid;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    int tc[4] = '{default: 0};

    always #2.5 clock = ~clock;

    field_model u_field (.clock(clock), .fast_in(fast_in), .run_switch(run_switch),
        .short_fault(short_fault));

    run_stop_io_supervisor #(.REARM_CYCLES(32'd50)) u_dut (.clock(clock), .rst_n(rst_n),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fast_in(fast_in),
        .run_switch(run_switch), .short_fault(short_fault), .exc_state(exc_state),
        .task_trigger(task_trigger), .out_drive(out_drive), .run_active(run_active),
        .irq(irq), .ext_time(ext_time), .ext_time_valid(ext_time_valid));

    // ==========
    // Monitors and hang guard
    always @(posedge clock) begin
        cycles++;
        for (int i = 0; i < 4; i++) begin
            if (task_trigger[i] === 1'b1) tc[i]++;
        end
        if (cycles == LIMIT) begin
            mismatches++;
            results();
        end
    end

    // ==========
    // Access and compare tasks
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [5:0] a, input logic [31:0] e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        check(n, rdata, e);
    endtask
    task automatic ck_run(input int n, input logic e);
        idle(n);
        check("run_active", 32'(run_active), 32'(e));
    endtask
    task automatic ck_out(input int n, input logic [7:0] e);
        idle(n);
        check("out_drive", 32'(out_drive), 32'(e));
    endtask
    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ==========
    // Test sequence
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        rchk("filt", REG_FILT, 32'(FILT_RST));
        rchk("in_cfg", REG_IN_CFG, 32'h0);
        rchk("unmapped", 6'h30, 32'h0);
        // Two ticks needed: a 100 cycle burst is lost
        wr_reg(REG_FILT, 32'h2);
        u_field.pulse(1, 100);
        idle(500);
        rchk("glitch", REG_STATUS, 32'h0);
        u_field.set_in(1, 1'b1, 3);
        idle(700);
        rchk("held", REG_STATUS, 32'h20);
        wr_reg(REG_FILT, 32'h0);
        u_field.set_in(1, 1'b0, 0);
        // In0 latched, in2 rising event, in3 falling event
        wr_reg(REG_IN_CFG, 32'h90A1);
        wr_reg(REG_SCAN, 32'h0);
        u_field.pulse(0, 3);
        idle(10);
        wr_reg(REG_SCAN, 32'h0);
        rchk("latch", REG_SCAN, 32'h1);
        wr_reg(REG_SCAN, 32'h0);
        rchk("latch_clr", REG_SCAN, 32'h0);
        u_field.set_in(0, 1'b1, 0);
        idle(10);
        wr_reg(REG_SCAN, 32'h0);
        wr_reg(REG_SCAN, 32'h0);
        u_field.set_in(0, 1'b0, 0);
        idle(10);
        wr_reg(REG_SCAN, 32'h0);
        rchk("latch_fall", REG_SCAN, 32'h0);
        u_field.pulse(2, 5);
        u_field.pulse(3, 5);
        idle(10);
        check("trig0", 32'(tc[0]), 32'h0);
        check("trig2", 32'(tc[2]), 32'h1);
        check("trig3", 32'(tc[3]), 32'h1);
        rchk("irq_stat", REG_IRQ_STAT, 32'hC);
        check("irq_off", 32'(irq), 32'h0);
        wr_reg(REG_IRQ_MASK, 32'h4);
        idle(2);
        check("irq_on", 32'(irq), 32'h1);
        wr_reg(REG_IRQ_STAT, 32'h4);
        idle(2);
        check("irq_clr", 32'(irq), 32'h0);
        wr_reg(REG_IN_CFG, 32'h30A1);
        u_field.pulse(2, 5);
        idle(10);
        check("trig2_both", 32'(tc[2]), 32'h3);
        // Run and stop sources
        wr_reg(REG_OUT_VAL, 32'hA5);
        wr_reg(REG_OUT_DEF, 32'h3C);
        wr_reg(REG_CMD, 32'h1);
        ck_run(40, 1'b0);
        ck_out(0, 8'h3C);
        u_field.set_ctl(1'b1, 1'b0);
        ck_run(40, 1'b1);
        ck_out(0, 8'hA5);
        @(posedge clock);
        exc_state <= 1'b1;
        ck_out(5, 8'h3C);
        @(posedge clock);
        exc_state <= 1'b0;
        wr_reg(REG_CMD, 32'h2);
        ck_run(5, 1'b0);
        wr_reg(REG_CMD, 32'h1);
        ck_run(5, 1'b1);
        wr_reg(REG_RS_CFG, 32'h3);
        ck_run(40, 1'b0);
        wr_reg(REG_RS_CFG, 32'h5);
        rchk("rs_cfg", REG_RS_CFG, 32'h3);
        wr_reg(REG_CMD, 32'h1);
        ck_run(40, 1'b0);
        u_field.set_in(1, 1'b1, 0);
        ck_run(40, 1'b1);
        u_field.set_ctl(1'b0, 1'b0);
        ck_run(40, 1'b0);
        u_field.set_in(1, 1'b0, 0);
        u_field.set_in(1, 1'b1, 0);
        ck_run(40, 1'b0);
        u_field.set_ctl(1'b1, 1'b0);
        ck_run(40, 1'b1);
        // Short circuit trip and rearm
        u_field.set_ctl(1'b1, 1'b1);
        ck_out(6, 8'h00);
        rchk("status_prot", REG_STATUS, 32'h23);
        rchk("irq_trip", REG_IRQ_STAT, 32'h3C);
        u_field.set_ctl(1'b1, 1'b0);
        ck_out(20, 8'h00);
        ck_out(60, 8'hA5);
        wr_reg(REG_OUT_CFG, 32'h1);
        u_field.set_ctl(1'b1, 1'b1);
        idle(6);
        u_field.set_ctl(1'b1, 1'b0);
        ck_out(150, 8'h00);
        wr_reg(REG_CMD, 32'h4);
        ck_out(5, 8'hA5);
        wr_reg(REG_TIME, 32'h1234_5678);
        #1;
        check("time_valid", 32'(ext_time_valid), 32'h1);
        check("time", ext_time, 32'h1234_5678);
        results();
    end
endmodule
`default_nettype wire
